/* File: common/word_decode_pkg.sv */
// constants, register map and field layout for the instruction word decoder
package word_decode_pkg;

  localparam int WORD_W   = 24;
  localparam int ADDR_W   = 12;
  localparam int OP_W     = 9;
  localparam int SEL_W    = 3;
  localparam int CHAR_W   = 6;
  localparam int PRIO_W   = 8;

  // field positions inside a 24-bit word, and the parity bit above it
  localparam int SIGN_BIT   = 23;
  localparam int OP_LSB     = 15;
  localparam int OP_MSB     = 23;
  localparam int OPHI_LSB   = 18;
  localparam int SUB_LSB    = 15;
  localparam int SUB_MSB    = 17;
  localparam int TSEL_LSB   = 12;
  localparam int TSEL_MSB   = 14;
  localparam int ADDR_MSB   = 11;
  localparam int PARITY_BIT = 24;

  // upper six opcode bits of the instructions whose bits 15-17 are not opcode
  localparam logic [5:0] INDEX_INCREMENT_TEST_OP = 6'h2c;
  localparam logic [5:0] INDEX_DECREMENT_TEST_OP = 6'h2d;
  localparam logic [5:0] IO_SETUP_OP             = 6'h30;
  localparam logic [5:0] IO_STORE_OP             = 6'h31;
  localparam logic [5:0] IO_LOAD_OP              = 6'h32;
  localparam logic [5:0] IO_SENSE_OP             = 6'h33;

  // odd parity over 24 data bits plus the parity bit
  localparam logic PARITY_ODD = 1'b1;

  // index registers live at core locations 1..7
  localparam logic [11:0] INDEX_FIRST = 12'h001;
  localparam logic [11:0] INDEX_LAST  = 12'h007;

  // wishbone word offsets (byte address bits 7:2)
  localparam logic [5:0] REG_LEFT_ACC    = 6'h00;
  localparam logic [5:0] REG_RIGHT_ACC   = 6'h01;
  localparam logic [5:0] REG_PROG_CNT    = 6'h02;
  localparam logic [5:0] REG_PRIO_REQ    = 6'h03;
  localparam logic [5:0] REG_PRIO_STAT   = 6'h04;
  localparam logic [5:0] REG_LAST_INSTR  = 6'h05;
  localparam logic [5:0] REG_DECODE      = 6'h06;
  localparam logic [5:0] REG_CHAR_SEL    = 6'h07;
  localparam logic [5:0] REG_CHAR_DATA   = 6'h08;
  localparam logic [5:0] REG_MAGNITUDE   = 6'h09;
  localparam logic [5:0] REG_INDEX_BASE  = 6'h10;

  // values after reset, and the program counter step
  localparam logic [23:0] ACC_RESET  = 24'h00_0000;
  localparam logic [11:0] PC_RESET   = 12'h000;
  localparam logic [7:0]  PRIO_RESET = 8'h00;
  localparam logic [11:0] PC_STEP    = 12'h001;

endpackage : word_decode_pkg

/* File: hw/instr_field_split.sv */
// field splitter for one 24-bit instruction word
`timescale 1ns/1ps
module instr_field_split
  import word_decode_pkg::*;
(
  input  wire logic [23:0] instr,
  output logic      [8:0]  op_field,
  output logic      [2:0]  index_sel,
  output logic      [11:0] operand_addr,
  output logic      [2:0]  sub_field,
  output logic             is_index_op,
  output logic             is_io_op
);
  import word_decode_pkg::*;

  wire [5:0] op_high;

  assign op_field     = instr[OP_MSB:OP_LSB];        // RULE5
  assign op_high      = instr[OP_MSB:OPHI_LSB];
  assign sub_field    = instr[SUB_MSB:SUB_LSB];
  assign index_sel    = instr[TSEL_MSB:TSEL_LSB];    // RULE8
  assign operand_addr = instr[ADDR_MSB:0];           // RULE9

  // these opcodes give up bits 15-17 to an amount or a unit number
  assign is_index_op  = (op_high == INDEX_INCREMENT_TEST_OP)
                      | (op_high == INDEX_DECREMENT_TEST_OP);   // RULE6
  assign is_io_op     = (op_high == IO_SETUP_OP) | (op_high == IO_STORE_OP)
                      | (op_high == IO_LOAD_OP)  | (op_high == IO_SENSE_OP);  // RULE7

endmodule // instr_field_split

/* File: hw/word_format_decode.sv */
// instruction decoder with accumulators, program counter and priority registers
`timescale 1ns/1ps

// Summary of operation
// RULE1 - bits are numbered 0 to 23 from the right, each a power of two
// RULE2 - bit 23 of a numeric word is the sign, one means negative
// RULE3 - 23 magnitude bits, point on the left, negatives two's complement
// RULE4 - a character word packs four six-bit characters
// RULE5 - opcode is taken from bits 15 to 23
// RULE6 - index step instructions use bits 15-17 as the step amount
// RULE7 - the four I/O instructions use bits 15-17 as unit select
// RULE8 - bits 12-14 select index register 1 to 7 for address modification
// RULE9 - bits 0-11 are the operand address or jump target
// RULE10 - seven index registers at core locations 1-7, used as 12 bits
// RULE11 - a 12-bit program counter updates at the end of each instruction
// RULE12 - eight request lines latch into a request register until serviced
// RULE13 - an 8-bit status register holds current level and program
// RULE14 - four priority levels, two programs each, eight slots
// RULE15 - left accumulator is the main 24-bit arithmetic register
// RULE16 - right accumulator holds low half, remainder and multiplier
// RULE17 - memory words carry 24 data bits plus one parity bit
// RULE18 - after each instruction a higher request starts an interrupt
// RULE19 - all decoded fields appear together in one step
// RULE20 - the program counter wraps from its maximum to zero
module word_format_decode
  import word_decode_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        MEM_VALID,
  input  wire logic        MEM_INSTR,
  input  wire logic [11:0] MEM_ADDR,
  input  wire logic [24:0] MEM_WORD,
  input  wire logic        INSTR_DONE,
  input  wire logic        TAKE_JUMP,
  input  wire logic [7:0]  REQ_LINES,
  output logic             DECODE_VALID,
  output logic      [8:0]  OPERATION_CODE_FIELD,
  output logic      [2:0]  INDEX_SELECT,
  output logic      [11:0] OPERAND_ADDRESS,
  output logic      [11:0] EFFECTIVE_ADDRESS,
  output logic      [2:0]  MODIFY_AMOUNT,
  output logic      [2:0]  IO_SELECT,
  output logic             IS_INDEX_OP,
  output logic             IS_IO_OP,
  output logic             PARITY_ERROR,
  output logic      [11:0] PROGRAM_COUNTER,
  output logic             INTERRUPT_START,
  output logic      [2:0]  INTERRUPT_SLOT
);
  import word_decode_pkg::*;

  // highest set bit; slot 7 and 6 form the top level
  function automatic logic [2:0] top_slot(input logic [7:0] v);
    logic [2:0] s;
    s = 3'd0;
    for (int i = 0; i < PRIO_W; i++)
    begin
      if (v[i])
        s = 3'(i);
    end
    return s;
  endfunction

  function automatic logic [23:0] merge_bytes(input logic [23:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [23:0] r;
    r = old_v;
    for (int b = 0; b < 3; b++)
    begin
      if (sel[b])
        r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  // sign and magnitude view of a two's complement word
  function automatic logic [22:0] magnitude(input logic [23:0] w);
    logic [23:0] neg;
    neg = (~w) + 24'h00_0001;
    return w[SIGN_BIT] ? neg[22:0] : w[22:0];   // RULE2 RULE3
  endfunction

  // registers
  logic [23:0] left_acc_reg;
  logic [23:0] right_acc_reg;
  logic [11:0] program_counter_reg;
  logic [7:0]  priority_request_register;
  logic [7:0]  priority_status_register;
  logic [23:0] instr_reg;
  logic [1:0]  char_sel_reg;
  logic [11:0] index_register [1:7];
  logic        ack_reg;
  logic [31:0] dat_reg;

  // decoded fields from the incoming word
  logic [8:0]  op_field;
  logic [2:0]  index_sel;
  logic [11:0] operand_addr;
  logic [2:0]  sub_field;
  logic        is_index_op;
  logic        is_io_op;

  instr_field_split u_split (
    .instr        (MEM_WORD[23:0]),
    .op_field     (op_field),
    .index_sel    (index_sel),
    .operand_addr (operand_addr),
    .sub_field    (sub_field),
    .is_index_op  (is_index_op),
    .is_io_op     (is_io_op)
  );

  // bus decode
  wire        bus_req     = CYC_I & STB_I & ~ack_reg;
  wire        bus_wr      = bus_req & WE_I;
  wire [5:0]  word_idx    = ADR_I[7:2];
  wire        hit_index   = (word_idx > REG_INDEX_BASE)
                          & (word_idx <= REG_INDEX_BASE + 6'd7);
  wire [2:0]  bus_ix      = word_idx[2:0];
  wire        wr_left     = bus_wr & (word_idx == REG_LEFT_ACC);
  wire        wr_right    = bus_wr & (word_idx == REG_RIGHT_ACC);
  wire        wr_pc       = bus_wr & (word_idx == REG_PROG_CNT);
  wire        wr_req_clr  = bus_wr & (word_idx == REG_PRIO_REQ) & SEL_I[0];
  wire        wr_status   = bus_wr & (word_idx == REG_PRIO_STAT) & SEL_I[0];
  wire        wr_char_sel = bus_wr & (word_idx == REG_CHAR_SEL) & SEL_I[0];
  wire        wr_ix       = bus_wr & hit_index;

  // core traffic
  wire        word_parity_bad = (^MEM_WORD) != PARITY_ODD;                 // RULE17
  wire        take_instr      = MEM_VALID & MEM_INSTR;
  wire        ix_loc          = (MEM_ADDR >= INDEX_FIRST) & (MEM_ADDR <= INDEX_LAST);
  wire        ix_load         = MEM_VALID & ~MEM_INSTR & ix_loc;              // RULE10
  wire [2:0]  mem_ix          = MEM_ADDR[2:0];

  // address modification through the selected index register
  wire        use_index    = (index_sel != 3'd0) & ~is_index_op;             // RULE8
  wire [11:0] ix_value     = use_index ? index_register[index_sel] : 12'h000;  // RULE10
  wire [11:0] eff_addr     = operand_addr + ix_value;

  // priority compare: request word against status word, as numbers
  wire        higher_pending = priority_request_register > priority_status_register;
  wire        start_irq      = INSTR_DONE & higher_pending;                  // RULE18
  wire [2:0]  irq_slot       = top_slot(priority_request_register);          // RULE14
  wire [7:0]  irq_slot_bit   = 8'h01 << irq_slot;

  // program counter: jump target or next location, wrapping at 12 bits
  wire [11:0] pc_inc  = program_counter_reg + PC_STEP;                       // RULE20
  wire [11:0] pc_next = TAKE_JUMP ? instr_reg[ADDR_MSB:0] : pc_inc;          // RULE9

  // character view of the left accumulator
  wire [5:0]  char_out = left_acc_reg[char_sel_reg*CHAR_W +: CHAR_W];         // RULE4
  wire [23:0] mag_view = {left_acc_reg[SIGN_BIT], magnitude(left_acc_reg)};

  wire [11:0] op_view_pad = {OPERATION_CODE_FIELD, 3'b000};
  wire [31:0] decode_view = {2'b00, IS_IO_OP, IS_INDEX_OP, PARITY_ERROR,
                             op_view_pad, INDEX_SELECT, OPERAND_ADDRESS};

  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    unique case (word_idx)
      REG_LEFT_ACC:   rd_data = {8'h00, left_acc_reg};                    // RULE15
      REG_RIGHT_ACC:  rd_data = {8'h00, right_acc_reg};                   // RULE16
      REG_PROG_CNT:   rd_data = {20'h0_0000, program_counter_reg};
      REG_PRIO_REQ:   rd_data = {24'h00_0000, priority_request_register};
      REG_PRIO_STAT:  rd_data = {24'h00_0000, priority_status_register};  // RULE13
      REG_LAST_INSTR: rd_data = {8'h00, instr_reg};
      REG_DECODE:     rd_data = decode_view;
      REG_CHAR_SEL:   rd_data = {30'h000_0000, char_sel_reg};
      REG_CHAR_DATA:  rd_data = {26'h00_0000, char_out};
      REG_MAGNITUDE:  rd_data = {8'h00, mag_view};                        // RULE1
      default:
      begin
        if (hit_index)
          rd_data = {20'h0_0000, index_register[bus_ix]};
      end
    endcase
  end

  // bus slave: one wait cycle, ack for one cycle, unmapped reads give zero
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req;
      if (bus_req & ~WE_I)
        dat_reg <= rd_data;
    end
  end

  assign ACK_O = ack_reg;
  assign DAT_O = dat_reg;

  // accumulators, written over the bus by byte lane
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      left_acc_reg  <= ACC_RESET;
      right_acc_reg <= ACC_RESET;
      char_sel_reg  <= 2'b00;
    end
    else
    begin
      if (wr_left)
        left_acc_reg <= merge_bytes(left_acc_reg, DAT_I, SEL_I);     // RULE15
      if (wr_right)
        right_acc_reg <= merge_bytes(right_acc_reg, DAT_I, SEL_I);   // RULE16
      if (wr_char_sel)
        char_sel_reg <= DAT_I[1:0];
    end
  end

  // index shadow follows every core write to locations 1..7
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (int i = 1; i <= 7; i++)
        index_register[i] <= 12'h000;
    end
    else
    begin
      if (ix_load)
        index_register[mem_ix] <= MEM_WORD[ADDR_MSB:0];     // RULE10
      else if (wr_ix)
        index_register[bus_ix] <= DAT_I[ADDR_MSB:0];
    end
  end

  // instruction end wins over a bus write in the same cycle
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      program_counter_reg <= PC_RESET;
    else if (INSTR_DONE)
      program_counter_reg <= pc_next;                       // RULE11
    else if (wr_pc)
      program_counter_reg <= DAT_I[ADDR_MSB:0];
  end

  assign PROGRAM_COUNTER = program_counter_reg;

  // request bits are sticky; a live line beats any clear
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      priority_request_register <= PRIO_RESET;
      priority_status_register  <= PRIO_RESET;
      INTERRUPT_START           <= 1'b0;
      INTERRUPT_SLOT            <= 3'd0;
    end
    else
    begin
      priority_request_register <= (priority_request_register
                                    & ~(wr_req_clr ? DAT_I[7:0] : 8'h00)
                                    & ~(start_irq ? irq_slot_bit : 8'h00))
                                   | REQ_LINES;                          // RULE12
      if (start_irq)
        priority_status_register <= irq_slot_bit;                        // RULE13 RULE14
      else if (wr_status)
        priority_status_register <= DAT_I[7:0];
      INTERRUPT_START <= start_irq;                                      // RULE18
      if (start_irq)
        INTERRUPT_SLOT <= irq_slot;
    end
  end

  // one decode step: every field is registered on the same edge
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      instr_reg            <= 24'h00_0000;
      DECODE_VALID         <= 1'b0;
      OPERATION_CODE_FIELD <= 9'h000;
      INDEX_SELECT         <= 3'd0;
      OPERAND_ADDRESS      <= 12'h000;
      EFFECTIVE_ADDRESS    <= 12'h000;
      MODIFY_AMOUNT        <= 3'd0;
      IO_SELECT            <= 3'd0;
      IS_INDEX_OP          <= 1'b0;
      IS_IO_OP             <= 1'b0;
      PARITY_ERROR         <= 1'b0;
    end
    else
    begin
      DECODE_VALID <= take_instr;                                       // RULE19
      if (MEM_VALID)
        PARITY_ERROR <= word_parity_bad;                                // RULE17
      if (take_instr)
      begin
        instr_reg            <= MEM_WORD[23:0];
        OPERATION_CODE_FIELD <= op_field;                               // RULE5
        INDEX_SELECT         <= index_sel;                              // RULE8
        OPERAND_ADDRESS      <= operand_addr;                           // RULE9
        EFFECTIVE_ADDRESS    <= eff_addr;
        MODIFY_AMOUNT        <= is_index_op ? sub_field : 3'd0;         // RULE6
        IO_SELECT            <= is_io_op ? sub_field : 3'd0;            // RULE7
        IS_INDEX_OP          <= is_index_op;
        IS_IO_OP             <= is_io_op;
      end
    end
  end

endmodule // word_format_decode

/* File: dv/word_decode_assertions.sv */
// port-level checks for the instruction word decoder
`timescale 1ns/1ps
module word_decode_assertions
  import word_decode_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        ACK_O,
  input wire logic        MEM_VALID,
  input wire logic        MEM_INSTR,
  input wire logic [24:0] MEM_WORD,
  input wire logic        INSTR_DONE,
  input wire logic        TAKE_JUMP,
  input wire logic        DECODE_VALID,
  input wire logic [8:0]  OPERATION_CODE_FIELD,
  input wire logic [2:0]  INDEX_SELECT,
  input wire logic [11:0] OPERAND_ADDRESS,
  input wire logic [2:0]  MODIFY_AMOUNT,
  input wire logic [2:0]  IO_SELECT,
  input wire logic        IS_INDEX_OP,
  input wire logic        IS_IO_OP,
  input wire logic        PARITY_ERROR,
  input wire logic [11:0] PROGRAM_COUNTER,
  input wire logic        INTERRUPT_START
);
  wire logic       fetch = MEM_VALID && MEM_INSTR;
  wire logic [5:0] hi    = MEM_WORD[23:18];
  wire logic       ix    = hi == INDEX_INCREMENT_TEST_OP || hi == INDEX_DECREMENT_TEST_OP;
  wire logic       io    = hi inside {IO_SETUP_OP, IO_STORE_OP, IO_LOAD_OP, IO_SENSE_OP};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  ack_once_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
    else $error("bus answer is not a single cycle");
  op_field_a: assert property (
    fetch |=> DECODE_VALID && OPERATION_CODE_FIELD == $past(MEM_WORD[23:15]))
    else $error("opcode field wrong after fetch");
  index_sel_a: assert property (fetch |=> INDEX_SELECT == $past(MEM_WORD[14:12]))
    else $error("index selector wrong after fetch");
  operand_a: assert property (fetch |=> OPERAND_ADDRESS == $past(MEM_WORD[11:0]))
    else $error("operand address wrong after fetch");
  modify_amt_a: assert property (
    fetch && ix |=> IS_INDEX_OP && MODIFY_AMOUNT == $past(MEM_WORD[17:15]))
    else $error("index step amount wrong");
  io_unit_a: assert property (
    fetch && io |=> IS_IO_OP && IO_SELECT == $past(MEM_WORD[17:15]))
    else $error("io unit select wrong");
  fields_hold_a: assert property (
    !fetch |=> !DECODE_VALID && $stable(OPERAND_ADDRESS) && $stable(OPERATION_CODE_FIELD))
    else $error("decoded fields moved without a fetch");
  parity_a: assert property (MEM_VALID |=> PARITY_ERROR == ~^$past(MEM_WORD))
    else $error("parity flag wrong");
  pc_step_a: assert property (
    INSTR_DONE && !TAKE_JUMP |=> PROGRAM_COUNTER == $past(PROGRAM_COUNTER) + 12'h001)
    else $error("program counter did not step");
  irq_cause_a: assert property ($rose(INTERRUPT_START) |-> $past(INSTR_DONE))
    else $error("interrupt started outside an instruction end");
endmodule // word_decode_assertions

/* File: dv/core_memory_model.sv */
// core memory model handing instruction and data words to the decoder
`timescale 1ns/1ps
module core_memory_model
(
  input  wire logic        clk,
  output logic             mem_valid = 1'b0,
  output logic             mem_instr = 1'b0,
  output logic      [11:0] mem_addr  = 12'h000,
  output logic      [24:0] mem_word  = 25'h000_0000
);
  // one word per call; idle lines flip so stale data is never mistaken
  task automatic send(input logic is_instr, input logic [11:0] addr,
                      input logic [23:0] data, input logic bad_par);
    @(posedge clk);
    mem_valid <= 1'b1;
    mem_instr <= is_instr;
    mem_addr  <= addr;
    mem_word  <= {(~^data) ^ bad_par, data};
    @(posedge clk);
    mem_valid <= 1'b0;
    mem_instr <= 1'b0;
    mem_addr  <= ~mem_addr;
    mem_word  <= ~mem_word;
  endtask
endmodule // core_memory_model

/* File: dv/tb_word_format_instruction_decode.sv */
// self-checking bench for the instruction word decoder
`timescale 1ns/1ps
module tb_word_format_instruction_decode;
  import word_decode_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, req = 1'b0, we = 1'b0, done = 1'b0, jump = 1'b0;
  logic        ack, mv, mi, dv, isx, isio, perr, irq;
  logic [7:0]  adr = 8'h00, lines = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_w = 32'h0000_0000, dat_r;
  logic [24:0] mw;
  logic [11:0] ma, ya, ea, pc;
  logic [8:0]  opf;
  logic [2:0]  ts, ka, na, slot;
  logic [5:0]  ops [7] = '{INDEX_INCREMENT_TEST_OP, INDEX_DECREMENT_TEST_OP, IO_SETUP_OP,
                          IO_STORE_OP, IO_LOAD_OP, IO_SENSE_OP, 6'h05};
  int          n_errors = 0;
  int          samples_checked = 0;
  word_format_decode uut (
    .CLK(clk), .RSTN(rstn), .CYC_I(req), .STB_I(req), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .MEM_VALID(mv),
    .MEM_INSTR(mi), .MEM_ADDR(ma), .MEM_WORD(mw), .INSTR_DONE(done), .TAKE_JUMP(jump),
    .REQ_LINES(lines), .DECODE_VALID(dv), .OPERATION_CODE_FIELD(opf), .INDEX_SELECT(ts),
    .OPERAND_ADDRESS(ya), .EFFECTIVE_ADDRESS(ea), .MODIFY_AMOUNT(ka), .IO_SELECT(na),
    .IS_INDEX_OP(isx), .IS_IO_OP(isio), .PARITY_ERROR(perr), .PROGRAM_COUNTER(pc),
    .INTERRUPT_START(irq), .INTERRUPT_SLOT(slot));
  core_memory_model mem (.clk(clk), .mem_valid(mv), .mem_instr(mi), .mem_addr(ma),
    .mem_word(mw));
  always #10 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    @(posedge clk);
    req   <= 1'b1;
    we    <= w;
    adr   <= {idx, 2'b00};
    sel   <= s;
    dat_w <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_r;
    req <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    wb(1'b1, idx, d, s, q);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, idx, 32'h0000_0000, 4'hF, q);
    chk(q, exp);
  endtask
  task automatic step(input logic j);
    @(posedge clk);
    done <= 1'b1;
    jump <= j;
    @(posedge clk);
    done <= 1'b0;
    jump <= 1'b0;
    #1;
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    lines <= v;
    @(posedge clk);
    lines <= 8'h00;
  endtask
  // index 3 holds 12'hFF0 in every fetch that names an index register
  function automatic logic [19:0] dec_exp(input logic [23:0] w);
    logic ix;
    logic io;
    ix = w[23:18] == INDEX_INCREMENT_TEST_OP || w[23:18] == INDEX_DECREMENT_TEST_OP;
    io = w[23:18] inside {IO_SETUP_OP, IO_STORE_OP, IO_LOAD_OP, IO_SENSE_OP};
    return {io, ix, io ? w[17:15] : 3'h0, ix ? w[17:15] : 3'h0,
            w[11:0] + ((w[14:12] != 3'h0 && !ix) ? 12'hFF0 : 12'h000)};
  endfunction
  task automatic fetch(input logic [23:0] w, input logic bad);
    mem.send(1'b1, 12'h000, w, bad);
    #1;
    chk(dv, 1'b1);
    chk({opf, ts, ya}, w);
    chk({isio, isx, na, ka, ea}, dec_exp(w));
    chk(perr, bad);
  endtask
  task automatic note(input string s);
    $display("test %s done, %0d mismatches so far", s, n_errors);
  endtask
  task automatic test_done;
    $display("%0d checks made, %0d mismatches", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({dv, irq, ack, pc}, 32'h0000_0000);
    rdc(REG_LEFT_ACC, 32'h0000_0000);
    rdc(REG_PRIO_STAT, 32'h0000_0000);
    note("reset");
    wr(REG_LEFT_ACC, 32'hFFFF_FFFF, 4'hF);
    rdc(REG_LEFT_ACC, 32'h00FF_FFFF);
    wr(REG_RIGHT_ACC, 32'h005A_A5C3, 4'hF);
    rdc(REG_RIGHT_ACC, 32'h005A_A5C3);
    wr(REG_LEFT_ACC, 32'h0080_0001, 4'hF);
    rdc(REG_MAGNITUDE, 32'h00FF_FFFF);
    wr(REG_LEFT_ACC, 32'h0012_3456, 4'hF);
    rdc(REG_MAGNITUDE, 32'h0012_3456);
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_CHAR_SEL, 32'(i), 4'hF);
      rdc(REG_CHAR_DATA, (32'h0012_3456 >> (6 * i)) & 32'h0000_003F);
    end
    wr(REG_LEFT_ACC, 32'hFFFF_FFFF, 4'h1);
    rdc(REG_LEFT_ACC, 32'h0012_34FF);
    rdc(6'h3F, 32'h0000_0000);
    note("registers");
    mem.send(1'b0, 12'h003, 24'hAB_CFF0, 1'b0);
    rdc(REG_INDEX_BASE + 6'h03, 32'h0000_0FF0);
    wr(REG_INDEX_BASE + 6'h07, 32'h0000_0123, 4'hF);
    rdc(REG_INDEX_BASE + 6'h07, 32'h0000_0123);
    for (int i = 0; i < 7; i++)
      fetch({ops[i], 3'(i * 3), 3'h3, 12'h020}, 1'b0);
    fetch(24'h14_02A5, 1'b1);
    rdc(REG_LAST_INSTR, 32'h0014_02A5);
    rdc(REG_DECODE, 32'h08A0_02A5);
    note("decode");
    wr(REG_PROG_CNT, 32'h0000_0FFF, 4'hF);
    rdc(REG_PROG_CNT, 32'h0000_0FFF);
    step(1'b0);
    chk(pc, 12'h000);
    step(1'b0);
    chk(pc, 12'h001);
    step(1'b1);
    chk(pc, 12'h2A5);
    note("program counter");
    pulse(8'h20);
    rdc(REG_PRIO_REQ, 32'h0000_0020);
    step(1'b0);
    chk({irq, slot}, 4'hD);
    rdc(REG_PRIO_STAT, 32'h0000_0020);
    rdc(REG_PRIO_REQ, 32'h0000_0000);
    pulse(8'h04);
    step(1'b0);
    chk(irq, 1'b0);
    pulse(8'h80);
    step(1'b0);
    chk({irq, slot}, 4'hF);
    rdc(REG_PRIO_STAT, 32'h0000_0080);
    wr(REG_PRIO_REQ, 32'h0000_0004, 4'hF);
    rdc(REG_PRIO_REQ, 32'h0000_0000);
    wr(REG_PRIO_STAT, 32'h0000_0001, 4'hF);
    rdc(REG_PRIO_STAT, 32'h0000_0001);
    note("priority");
    test_done();
  end
  initial
  begin
    #400_000;
    n_errors++;
    test_done();
  end
endmodule // tb_word_format_instruction_decode

bind word_format_decode word_decode_assertions chk_i (
  .CLK(CLK), .RSTN(RSTN), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O),
  .MEM_VALID(MEM_VALID), .MEM_INSTR(MEM_INSTR), .MEM_WORD(MEM_WORD),
  .INSTR_DONE(INSTR_DONE), .TAKE_JUMP(TAKE_JUMP), .DECODE_VALID(DECODE_VALID),
  .OPERATION_CODE_FIELD(OPERATION_CODE_FIELD), .INDEX_SELECT(INDEX_SELECT),
  .OPERAND_ADDRESS(OPERAND_ADDRESS), .MODIFY_AMOUNT(MODIFY_AMOUNT), .IO_SELECT(IO_SELECT),
  .IS_INDEX_OP(IS_INDEX_OP), .IS_IO_OP(IS_IO_OP), .PARITY_ERROR(PARITY_ERROR),
  .PROGRAM_COUNTER(PROGRAM_COUNTER), .INTERRUPT_START(INTERRUPT_START));
